/* src/flash_poll_map.svh */
// Register offsets, field positions and timing counts of the flash status poller
`ifndef FLASH_POLL_MAP_SVH
`define FLASH_POLL_MAP_SVH

// APB register byte offsets
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_LIMIT         12'h008
`define REG_LAST          12'h00C
// Control fields
`define CTRL_START_BIT    0
`define CTRL_WORD_BIT     1
`define CTRL_ABORT_BIT    2
// Status fields
`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1
`define STAT_FAIL_BIT     2
`define STAT_TMO_BIT      3
`define STAT_RDY_BIT      4
// Status bit positions in the low data byte
`define TOGGLE_ONE_POS    6
`define TIME_LIMIT_POS    5
// Reset value of the iteration limit
`define LIMIT_RESET       16'hFFFF
// Read strobe timing: 100 ns low time at 50 ns clock
`define READ_LOW_NS       100
`define CLK_NS            50
`define READ_LOW_CYC      ((`READ_LOW_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* src/flash_poll_pkg.sv */
// Types shared by the flash status poller
package flash_poll_pkg;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } strobe_t;

  typedef enum logic [1:0] {
    RES_NONE = 2'b00,
    RES_DONE = 2'b01,
    RES_FAIL = 2'b10,
    RES_TMO  = 2'b11
  } result_t;
endpackage

/* src/flash_read_cycle.sv */
// One flash read cycle: assert chip and output enable, sample the data bus
`timescale 1ns/1ns
`default_nettype none
`include "flash_poll_map.svh"
module flash_read_cycle
  import flash_poll_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request
  input  wire logic        start,
  output logic             done,
  output logic [15:0]      data,
  // Flash pins
  output strobe_t          strobe,
  input  wire logic [15:0] dq_in
);
  logic [3:0] cnt;
  logic       active;
  wire        last_cycle = active && (cnt == 4'(`READ_LOW_CYC - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active <= 1'b0;
      cnt    <= 4'h0;
      data   <= 16'h0000;
      done   <= 1'b0;
    end
    else
    begin
      done <= last_cycle;
      if (start && !active)
      begin
        active <= 1'b1;
        cnt    <= 4'h0;
      end
      else if (last_cycle)
      begin
        active <= 1'b0;
        data   <= dq_in;
      end
      else if (active)
        cnt <= cnt + 4'h1;
    end
  end

  // Write enable stays high so a read can never start a write cycle
  assign strobe.ce_n = ~active;
  assign strobe.oe_n = ~active;
  assign strobe.we_n = 1'b1;
endmodule // flash_read_cycle
`default_nettype wire

/* src/flash_status_poller.sv */
// APB-controlled toggle-bit status poller for a parallel flash
`timescale 1ns/1ns
`default_nettype none
`include "flash_poll_map.svh"
module flash_status_poller
  import flash_poll_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  output strobe_t          flash_strobe,
  output logic             word_mode,
  output logic             top_data_or_lsb_addr_out,
  output logic             top_data_or_lsb_addr_oe,
  input  wire logic [15:0] dq_in,
  input  wire logic        ready_busy_n,
  // Busy indication to system
  output logic             poll_busy
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_READ_A = 3'b001,
    ST_READ_B = 3'b010,
    ST_CHECK  = 3'b011,
    ST_RECHK  = 3'b100
  } state_t;

  state_t      state;
  state_t      next_state;
  logic        word_cfg;
  logic [15:0] limit;
  logic [15:0] iter;
  logic [15:0] last_data;
  logic [7:0]  first_byte;
  result_t     result;
  logic        rd_start;
  logic        rd_done;
  logic [15:0] rd_data;
  logic        second_pass;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_wr     = psel && penable && pwrite;
  wire sel_ctrl   = (paddr == `REG_CTRL);
  wire sel_status = (paddr == `REG_STATUS);
  wire sel_limit  = (paddr == `REG_LIMIT);
  wire sel_last   = (paddr == `REG_LAST);
  wire mapped     = sel_ctrl || sel_status || sel_limit || sel_last;
  wire start_cmd  = apb_wr && sel_ctrl && pwdata[`CTRL_START_BIT];
  wire abort_cmd  = apb_wr && sel_ctrl && pwdata[`CTRL_ABORT_BIT];
  wire busy       = (state != ST_IDLE);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = sel_ctrl   ? {30'h0, word_cfg, 1'b0} :
                   sel_status ? {27'h0, ready_busy_n, result == RES_TMO,
                                 result == RES_FAIL, result == RES_DONE, busy} :
                   sel_limit  ? {16'h0, limit} :
                   sel_last   ? {16'h0, last_data} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Toggle comparison
  // ----------------------------------------------------------------
  // Only the low byte carries status, in either width mode
  wire [7:0] new_byte = rd_data[7:0];
  wire toggling = first_byte[`TOGGLE_ONE_POS] != new_byte[`TOGGLE_ONE_POS];
  wire tl_high  = new_byte[`TIME_LIMIT_POS];
  wire at_limit = (iter >= limit);

  // ----------------------------------------------------------------
  // Poll sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = start_cmd ? ST_READ_A : ST_IDLE;
      ST_READ_A: next_state = rd_done ? ST_READ_B : ST_READ_A;
      ST_READ_B: next_state = rd_done ? (second_pass ? ST_RECHK : ST_CHECK) : ST_READ_B;
      ST_CHECK:  next_state = !toggling ? ST_IDLE :
                              tl_high   ? ST_READ_A :
                              at_limit  ? ST_IDLE : ST_READ_A;
      ST_RECHK:  next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
    if (abort_cmd)
      next_state = ST_IDLE;
  end

  assign rd_start = (state == ST_READ_A || state == ST_READ_B) && !rd_done;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state       <= ST_IDLE;
      word_cfg    <= 1'b0;
      limit       <= `LIMIT_RESET;
      iter        <= 16'h0000;
      last_data   <= 16'h0000;
      first_byte  <= 8'h00;
      result      <= RES_NONE;
      second_pass <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (apb_wr && sel_ctrl && !busy)
        word_cfg <= pwdata[`CTRL_WORD_BIT];
      if (apb_wr && sel_limit)
        limit <= pwdata[15:0];
      if (state == ST_READ_A && rd_done)
        first_byte <= rd_data[7:0];
      if (rd_done)
        last_data <= rd_data;
      case (state)
        ST_IDLE:
          if (start_cmd)
          begin
            // Any restart begins from the first read pair
            iter        <= 16'h0000;
            second_pass <= 1'b0;
            result      <= RES_NONE;
          end
        ST_CHECK:
          begin
            iter <= iter + 16'h0001;
            if (!toggling)
              result <= RES_DONE;
            else if (tl_high)
              second_pass <= 1'b1;
            else if (at_limit)
              result <= RES_TMO;
          end
        ST_RECHK:
          result <= toggling ? RES_FAIL : RES_DONE;
        default:
          ;
      endcase
    end
  end

  flash_read_cycle u_read (
    .clk    (clk),
    .rst    (rst),
    .start  (rd_start),
    .done   (rd_done),
    .data   (rd_data),
    .strobe (flash_strobe),
    .dq_in  (dq_in)
  );

  // Byte mode: top data pin becomes address bit, kept at zero for status reads
  assign word_mode                = word_cfg;
  assign top_data_or_lsb_addr_out = 1'b0;
  assign top_data_or_lsb_addr_oe  = !word_cfg;
  assign poll_busy                = busy;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  no_write_strobe_a: assert property (@(posedge clk) disable iff (rst) flash_strobe.we_n)
    else $error("write enable asserted by poller");
  read_oe_pair_a: assert property (@(posedge clk) disable iff (rst)
      !flash_strobe.oe_n |-> !flash_strobe.ce_n)
    else $error("output enable without chip enable");
  stable_done_a: assert property (@(posedge clk) disable iff (rst)
      (state == ST_CHECK && !toggling) |=> (result == RES_DONE && state == ST_IDLE))
    else $error("stable toggle not reported done");
  recheck_path_a: assert property (@(posedge clk) disable iff (rst)
      (state == ST_CHECK && toggling && tl_high && !abort_cmd) |=> (state == ST_READ_A && second_pass))
    else $error("time limit high did not trigger recheck");
  timeout_flag_a: assert property (@(posedge clk) disable iff (rst)
      (state == ST_CHECK && toggling && !tl_high && at_limit) |=> result == RES_TMO)
    else $error("iteration limit not reported");
  restart_clear_a: assert property (@(posedge clk) disable iff (rst)
      (state == ST_IDLE && start_cmd) |=> (iter == 16'h0000 && !second_pass))
    else $error("restart did not begin from first step");
  two_reads_a: assert property (@(posedge clk) disable iff (rst)
      (state == ST_IDLE && start_cmd) |=> (state == ST_READ_A) ##[1:20] (state == ST_READ_B))
    else $error("status check lacks two reads");
  byte_pin_a: assert property (@(posedge clk) disable iff (rst)
      top_data_or_lsb_addr_oe == !word_mode)
    else $error("top data pin drive mismatch");
  abort_idle_a: assert property (@(posedge clk) disable iff (rst)
      abort_cmd |=> (state == ST_IDLE))
    else $error("abort did not stop the poll");
  word_lock_a: assert property (@(posedge clk) disable iff (rst)
      (busy && apb_wr && sel_ctrl) |=> (word_cfg == $past(word_cfg)))
    else $error("width select changed during a poll");
endmodule // flash_status_poller
`default_nettype wire

/* bench/flash_dev_model.sv */
// Behavioural flash device that answers toggle-bit status reads
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model
  import flash_poll_pkg::*;
(
  // Flash pins
  input  wire strobe_t    strobe,
  output logic [15:0]     dq,
  output logic            rb_oe,
  // Scenario control
  input  wire logic       restart,
  input  wire logic [7:0] toggles,
  input  wire logic       over_limit,
  input  wire logic       erase,
  input  wire logic       busy,
  // Write cycles seen
  output logic [7:0]      writes
);
  logic [7:0] left     = 8'h00;
  logic       tog      = 1'b0;
  logic       tog_two  = 1'b0;
  logic [7:0] wr_count = 8'h00;
  logic [7:0] stat;
  wire        rd       = !strobe.ce_n && !strobe.oe_n;
  wire        wr_cyc   = !strobe.ce_n && !strobe.we_n && strobe.oe_n;

  // Each read start flips the toggle bits until the embedded run ends
  always @(posedge rd or posedge restart)
  begin
    if (restart)
      left = toggles;
    else if (left != 8'h00)
    begin
      tog     = ~tog;
      tog_two = ~tog_two;
      left    = left - 8'h01;
    end
  end

  // No command sequence can start without write cycles, so array, busy and lockout stay put
  always @(posedge wr_cyc)
    wr_count <= wr_count + 8'h01;
  assign writes = wr_count;

  // Program: poll bit is complement of written 0, bit two 1; erase: poll bit 0, bit two toggles
  assign stat  = {!erase, tog, over_limit, 2'b00, erase ? tog_two : 1'b1, 2'b00};
  // A released bus shows the inverse so a stale value never passes
  assign dq    = rd ? {8'h00, stat} : ~{8'h00, stat};
  // Scenario holds busy for a running operation or a reset pulse, drops it on erase suspend
  assign rb_oe = busy;
endmodule // flash_dev_model
`default_nettype wire

/* bench/flash_status_poller_tb.sv */
// Self-checking bench for the flash status poller
`timescale 1ns/1ns
`default_nettype none
`include "flash_poll_map.svh"
module flash_status_poller_tb;
  import flash_poll_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  strobe_t     flash_strobe;
  logic        word_mode;
  logic        lsb_out;
  logic        lsb_oe;
  logic [15:0] dq;
  logic        rb_oe;
  wire         rb = rb_oe ? 1'b0 : 1'b1;
  logic        poll_busy;
  logic        restart = 1'b0;
  logic [7:0]  toggles = 8'h00;
  logic        over_limit = 1'b0;
  logic        busy = 1'b0;
  logic        erase = 1'b0;
  logic [7:0]  dev_writes;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors = 0;
  int          cmp_count = 0;

  flash_status_poller DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_strobe(flash_strobe), .word_mode(word_mode), .top_data_or_lsb_addr_out(lsb_out),
    .top_data_or_lsb_addr_oe(lsb_oe), .dq_in(dq), .ready_busy_n(rb), .poll_busy(poll_busy));
  flash_dev_model DEV (.strobe(flash_strobe), .dq(dq), .rb_oe(rb_oe), .restart(restart),
    .toggles(toggles), .over_limit(over_limit), .erase(erase), .busy(busy), .writes(dev_writes));

  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Runs one poll against a device that toggles a set number of times
  task automatic poll(input logic [7:0] n, input logic flag, input logic [3:0] exp, input string name);
    toggles    <= n;
    over_limit <= flag;
    restart    <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h0000_0001);
    @(posedge clk);
    for (int i = 0; i < 5000 && poll_busy !== 1'b0; i++)
      @(posedge clk);
    if (poll_busy !== 1'b0)
    begin
      num_errors++;
      $display("wrong value at %0t: %s poll never ended", $time, name);
    end
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({28'h0, rdat[3:0]}, {28'h0, exp}, name);
    $display("test %s finished", name);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #(50 * 60000);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk({29'h0, word_mode, lsb_oe, lsb_out}, 32'h0000_0002, "reset pins");
    apb(1'b0, `REG_LIMIT, 32'h0);
    chk(rdat, 32'h0000_FFFF, "limit reset");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rerr}, 32'h0000_0001, "unmapped");
    chk(rdat, 32'h0000_0000, "unmapped data");
    $display("test reset finished");
    poll(8'h00, 1'b0, 4'b0010, "stable");
    apb(1'b0, `REG_LAST, 32'h0);
    chk(rdat & 32'hFFFF_FFBF, 32'h0000_0084, "program status word");
    chk({31'h0, rerr}, 32'h0000_0000, "mapped read");
    erase <= 1'b1;
    poll(8'h05, 1'b0, 4'b0010, "slow");
    apb(1'b0, `REG_LAST, 32'h0);
    chk(rdat & 32'hFFFF_FFBB, 32'h0000_0000, "erase status word");
    erase <= 1'b0;
    poll(8'h02, 1'b1, 4'b0010, "late stop");
    poll(8'hFF, 1'b1, 4'b0100, "fail");
    apb(1'b1, `REG_LIMIT, 32'h0000_0003);
    poll(8'hFF, 1'b0, 4'b1000, "timeout");
    // Break off a running poll: width select must hold, result starts cleared
    apb(1'b1, `REG_CTRL, 32'h0000_0001);
    repeat (8) @(posedge clk);
    apb(1'b1, `REG_CTRL, 32'h0000_0002);
    apb(1'b1, `REG_CTRL, 32'h0000_0004);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({28'h0, rdat[3:0]}, 32'h0000_0000, "abort status");
    apb(1'b0, `REG_CTRL, 32'h0);
    chk({31'h0, rdat[`CTRL_WORD_BIT]}, 32'h0, "word locked while busy");
    $display("test abort finished");
    busy <= 1'b1;
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({31'h0, rdat[`STAT_RDY_BIT]}, 32'h0, "busy line");
    busy <= 1'b0;
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({31'h0, rdat[`STAT_RDY_BIT]}, 32'h1, "ready line");
    apb(1'b1, `REG_CTRL, 32'h0000_0002);
    @(posedge clk);
    chk({29'h0, word_mode, lsb_oe, lsb_out}, 32'h0000_0004, "word pins");
    apb(1'b0, `REG_CTRL, 32'h0);
    chk({31'h0, rdat[`CTRL_WORD_BIT]}, 32'h1, "word readback");
    chk({24'h0, dev_writes}, 32'h0000_0000, "write cycles");
    $display("test pins finished");
    tally_and_finish();
  end
endmodule // flash_status_poller_tb
`default_nettype wire
